// ===== verilog/spca_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the speed/position changeover axis. Definitions only.
`ifndef SPCA_REGS_SVH
`define SPCA_REGS_SVH

// ==========================================================
// Offsets (byte addresses, one 32-bit word each)
`define SPCA_OFS_CTRL 8'h00
`define SPCA_OFS_MOVE 8'h04
`define SPCA_OFS_SPEED 8'h08
`define SPCA_OFS_MCHG 8'h0C
`define SPCA_OFS_ACCEL 8'h10
`define SPCA_OFS_LIM_UP 8'h14
`define SPCA_OFS_LIM_LO 8'h18
`define SPCA_OFS_STATUS 8'h1C
`define SPCA_OFS_FEED 8'h20
`define SPCA_OFS_CHGAMT 8'h24
`define SPCA_OFS_ERROR 8'h28

// ==========================================================
// Control word fields
`define SPCA_CTRL_START 0
`define SPCA_CTRL_DIR 1
`define SPCA_CTRL_ENABLE 2
`define SPCA_CTRL_MODE_LO 4
`define SPCA_CTRL_MODE_HI 5
`define SPCA_CTRL_DEGREE 6
`define SPCA_CTRL_INFINITE 7
`define SPCA_CTRL_CONTPATH 8
`define SPCA_CTRL_PREVCONT 9
`define SPCA_CTRL_STOP 10

// Status word bits
`define SPCA_ST_SPEEDCTL 0
`define SPCA_ST_LATCH 1
`define SPCA_ST_BUSY 2
`define SPCA_ST_DONE 3

// ==========================================================
// Codes, reset values, timing
`define SPCA_ERR_STROKE_UP 16'h01FB
`define SPCA_ERR_STROKE_LO 16'h01FC
`define SPCA_ERR_CONTPATH 16'h0204
`define SPCA_ERR_METHOD 16'h020C
`define SPCA_WARN_ACCEL 16'h01FC
`define SPCA_RST_ACCEL 32'h0000_0001
`define SPCA_RST_LIM_UP 32'h7FFF_FFFF
`define SPCA_RST_LIM_LO 32'h8000_0000
`define SPCA_LATCH_TIME_MS 1
`define SPCA_CLK_KHZ 125000

`endif

// ===== verilog/spca_pkg.sv
// Types shared by the speed/position changeover axis.
// Assumes nothing of its surroundings.
`default_nettype none
package spca_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SPEED = 2'h1,
    ST_POS = 2'h2,
    ST_STOP = 2'h3
  } spca_state_e;
  typedef logic [31:0] spca_word_t;
endpackage
`default_nettype wire

// ===== verilog/spca_axis.sv
// Speed/position changeover axis: APB register slave plus motion core.
// Assumes one 125 MHz clock, a changeover input synchronous to it, and
// a servo drive that integrates the per-cycle step on cmd_step.
`timescale 1ns/1ps
`default_nettype none
`include "spca_regs.svh"

// Function
// - Run at command speed, then travel exact amount
// - External changeover input triggers position control
// - Enable must be on when input rises
// - Enable and input on at start: position only
// - Status b0 set during speed section
// - Mode 0: feed held, updates after changeover
// - Mode 1: feed updated in both sections
// - Mode 2: feed cleared at start, updates later
// - Status b1 set 1ms after input
// - Amount change accepted only in speed section
// - Write to change register is a request
// - New amount replaces programmed amount at changeover
// - Effective amount copied to monitor at changeover
// - Continuous path pattern refuses start, error 516
// - Previous entry continuous path: 516, decelerate
// - Short amount decelerates right at changeover
// - Changeover while accelerating raises warning 508
// - Stroke check in mode 1 only, 507/508
// - Degree unit skips stroke check
// - Infinite length mode refuses start, error 524
module spca_axis #(
  parameter int unsigned LATCH_CYC = `SPCA_LATCH_TIME_MS * `SPCA_CLK_KHZ
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Changeover input
  input wire logic spc_in,
  // Command to servo drive
  output logic [31:0] cmd_step,
  output logic cmd_dir
);

  // ==========================================================
  // Declarations
  spca_pkg::spca_state_e state_ff, nxt_state;
  spca_pkg::spca_word_t move_ff, nxt_move, speed_cfg_ff, nxt_speed_cfg;
  spca_pkg::spca_word_t accel_ff, nxt_accel, lim_up_ff, nxt_lim_up;
  spca_pkg::spca_word_t lim_lo_ff, nxt_lim_lo, mchg_val_ff, nxt_mchg_val;
  spca_pkg::spca_word_t feed_ff, nxt_feed, chg_amt_ff, nxt_chg_amt;
  spca_pkg::spca_word_t speed_ff, nxt_speed, rem_ff, nxt_rem;
  spca_pkg::spca_word_t step_ff, nxt_step, prdata_ff, nxt_prdata, lcnt_ff, nxt_lcnt;
  logic [15:0] err_ff, nxt_err, warn_ff, nxt_warn;
  logic [10:0] ctrl_ff, nxt_ctrl;
  logic dir_ff, nxt_dir, upd_ff, nxt_upd, stroke_ff, nxt_stroke;
  logic mchg_ok_ff, nxt_mchg_ok, latch_ff, nxt_latch, done_ff, nxt_done;
  logic spc_prev_ff, nxt_spc_prev;
  logic wr_en, setup, hit, start_req, stop_req, spc_edge, accel_busy, en;
  logic [1:0] mode;
  spca_pkg::spca_word_t eff_amt, pos_step, feed_step, ramp_up;
  logic [63:0] need_dist, kin;

  function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
    at = (a == ofs);
  endfunction

  // ==========================================================
  // APB decode; zero wait states, read data captured in setup
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign hit = at(paddr, `SPCA_OFS_CTRL) | at(paddr, `SPCA_OFS_MOVE) |
               at(paddr, `SPCA_OFS_SPEED) | at(paddr, `SPCA_OFS_MCHG) |
               at(paddr, `SPCA_OFS_ACCEL) | at(paddr, `SPCA_OFS_LIM_UP) |
               at(paddr, `SPCA_OFS_LIM_LO) | at(paddr, `SPCA_OFS_STATUS) |
               at(paddr, `SPCA_OFS_FEED) | at(paddr, `SPCA_OFS_CHGAMT) |
               at(paddr, `SPCA_OFS_ERROR);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_ff;
  assign cmd_step = step_ff;
  assign cmd_dir = dir_ff;

  assign start_req = wr_en & at(paddr, `SPCA_OFS_CTRL) & pwdata[`SPCA_CTRL_START];
  assign stop_req = wr_en & at(paddr, `SPCA_OFS_CTRL) & pwdata[`SPCA_CTRL_STOP];
  assign en = ctrl_ff[`SPCA_CTRL_ENABLE];
  assign mode = ctrl_ff[`SPCA_CTRL_MODE_HI:`SPCA_CTRL_MODE_LO];
  assign spc_edge = spc_in & ~spc_prev_ff;
  assign accel_busy = speed_ff < speed_cfg_ff;
  assign eff_amt = mchg_ok_ff ? mchg_val_ff : move_ff;
  assign ramp_up = (speed_cfg_ff - speed_ff > accel_ff) ? speed_ff + accel_ff : speed_cfg_ff;
  assign pos_step = (speed_ff < rem_ff) ? speed_ff : rem_ff;
  assign need_dist = {32'h0000_0000, rem_ff} * {31'h0000_0000, accel_ff, 1'b0};
  assign kin = {32'h0000_0000, speed_ff} * {32'h0000_0000, speed_ff};
  assign feed_step = (state_ff == spca_pkg::ST_POS) ? pos_step : speed_ff;

  // ==========================================================
  // Register file next state
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_move = move_ff;
    nxt_speed_cfg = speed_cfg_ff;
    nxt_accel = accel_ff;
    nxt_lim_up = lim_up_ff;
    nxt_lim_lo = lim_lo_ff;
    nxt_prdata = prdata_ff;
    if (wr_en) begin
      unique case (1'b1)
        at(paddr, `SPCA_OFS_CTRL): nxt_ctrl = {1'b0, pwdata[9:1], 1'b0};
        at(paddr, `SPCA_OFS_MOVE): nxt_move = pwdata;
        at(paddr, `SPCA_OFS_SPEED): nxt_speed_cfg = pwdata;
        at(paddr, `SPCA_OFS_ACCEL): nxt_accel = (pwdata == 32'h0) ? 32'h1 : pwdata;
        at(paddr, `SPCA_OFS_LIM_UP): nxt_lim_up = pwdata;
        at(paddr, `SPCA_OFS_LIM_LO): nxt_lim_lo = pwdata;
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (setup) begin
      nxt_prdata = 32'h0;
      unique case (1'b1)
        at(paddr, `SPCA_OFS_CTRL): nxt_prdata = {21'h0, ctrl_ff};
        at(paddr, `SPCA_OFS_MOVE): nxt_prdata = move_ff;
        at(paddr, `SPCA_OFS_SPEED): nxt_prdata = speed_cfg_ff;
        at(paddr, `SPCA_OFS_MCHG): nxt_prdata = mchg_val_ff;
        at(paddr, `SPCA_OFS_ACCEL): nxt_prdata = accel_ff;
        at(paddr, `SPCA_OFS_LIM_UP): nxt_prdata = lim_up_ff;
        at(paddr, `SPCA_OFS_LIM_LO): nxt_prdata = lim_lo_ff;
        at(paddr, `SPCA_OFS_STATUS): nxt_prdata = {28'h0, done_ff,
          (state_ff != spca_pkg::ST_IDLE), latch_ff, (state_ff == spca_pkg::ST_SPEED)};
        at(paddr, `SPCA_OFS_FEED): nxt_prdata = feed_ff;
        at(paddr, `SPCA_OFS_CHGAMT): nxt_prdata = chg_amt_ff;
        at(paddr, `SPCA_OFS_ERROR): nxt_prdata = {warn_ff, err_ff};
        default: nxt_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_ff <= 11'h000;
      move_ff <= 32'h0;
      speed_cfg_ff <= 32'h0;
      accel_ff <= `SPCA_RST_ACCEL;
      lim_up_ff <= `SPCA_RST_LIM_UP;
      lim_lo_ff <= `SPCA_RST_LIM_LO;
      prdata_ff <= 32'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      move_ff <= nxt_move;
      speed_cfg_ff <= nxt_speed_cfg;
      accel_ff <= nxt_accel;
      lim_up_ff <= nxt_lim_up;
      lim_lo_ff <= nxt_lim_lo;
      prdata_ff <= nxt_prdata;
    end
  end

  // ==========================================================
  // Motion core next state
  always_comb begin
    nxt_state = state_ff;
    nxt_speed = speed_ff;
    nxt_rem = rem_ff;
    nxt_step = 32'h0;
    nxt_feed = feed_ff;
    nxt_chg_amt = chg_amt_ff;
    nxt_dir = dir_ff;
    nxt_upd = upd_ff;
    nxt_stroke = stroke_ff;
    nxt_mchg_ok = mchg_ok_ff;
    nxt_mchg_val = mchg_val_ff;
    nxt_latch = latch_ff;
    nxt_lcnt = (lcnt_ff != 32'h0) ? lcnt_ff - 32'h1 : 32'h0;
    nxt_done = done_ff;
    nxt_err = err_ff;
    nxt_warn = warn_ff;
    nxt_spc_prev = spc_in;
    // Software clears codes; a code raised in the same cycle wins below
    if (wr_en && at(paddr, `SPCA_OFS_ERROR)) begin
      nxt_err = 16'h0;
      nxt_warn = 16'h0;
    end
    if (lcnt_ff == 32'h1) begin
      nxt_latch = 1'b1;
    end
    if (upd_ff && state_ff != spca_pkg::ST_IDLE) begin
      nxt_feed = dir_ff ? feed_ff - feed_step : feed_ff + feed_step;
    end
    unique case (state_ff)
      spca_pkg::ST_IDLE: begin
        // Feed value may be preset only while the axis stands still
        if (wr_en && at(paddr, `SPCA_OFS_FEED)) begin
          nxt_feed = pwdata;
        end
        if (start_req) begin
          if (pwdata[`SPCA_CTRL_CONTPATH]) begin
            nxt_err = `SPCA_ERR_CONTPATH;
          end else if (pwdata[`SPCA_CTRL_INFINITE]) begin
            nxt_err = `SPCA_ERR_METHOD;
          end else begin
            nxt_dir = pwdata[`SPCA_CTRL_DIR];
            nxt_upd = (pwdata[`SPCA_CTRL_MODE_HI:`SPCA_CTRL_MODE_LO] == 2'h1);
            nxt_stroke = 1'b0;
            nxt_mchg_ok = 1'b0;
            nxt_latch = 1'b0;
            // A timer left over from a short earlier run must not set the new latch
            nxt_lcnt = 32'h0;
            nxt_done = 1'b0;
            if (pwdata[`SPCA_CTRL_MODE_HI:`SPCA_CTRL_MODE_LO] == 2'h2) begin
              nxt_feed = 32'h0;
            end
            if (pwdata[`SPCA_CTRL_PREVCONT]) begin
              nxt_err = `SPCA_ERR_CONTPATH;
              nxt_state = spca_pkg::ST_STOP;
            end else if (pwdata[`SPCA_CTRL_ENABLE] && spc_in) begin
              nxt_state = spca_pkg::ST_POS;
              nxt_upd = 1'b1;
              nxt_rem = move_ff;
              nxt_chg_amt = move_ff;
              nxt_lcnt = LATCH_CYC;
            end else begin
              nxt_state = spca_pkg::ST_SPEED;
            end
          end
        end
      end
      spca_pkg::ST_SPEED: begin
        nxt_speed = ramp_up;
        nxt_step = speed_ff;
        if (wr_en && at(paddr, `SPCA_OFS_MCHG)) begin
          nxt_mchg_val = pwdata;
          nxt_mchg_ok = 1'b1;
        end
        // Limit check sees the feed value only when it is being updated
        if (upd_ff && !ctrl_ff[`SPCA_CTRL_DEGREE] &&
            ($signed(nxt_feed) > $signed(lim_up_ff) ||
             $signed(nxt_feed) < $signed(lim_lo_ff))) begin
          nxt_stroke = 1'b1;
        end
        if (stop_req) begin
          nxt_state = spca_pkg::ST_STOP;
        end else if (spc_edge && en) begin
          nxt_lcnt = LATCH_CYC;
          if (stroke_ff) begin
            nxt_err = dir_ff ? `SPCA_ERR_STROKE_LO : `SPCA_ERR_STROKE_UP;
            nxt_state = spca_pkg::ST_STOP;
          end else begin
            if (accel_busy) begin
              nxt_warn = `SPCA_WARN_ACCEL;
            end
            nxt_state = spca_pkg::ST_POS;
            nxt_upd = 1'b1;
            nxt_rem = eff_amt;
            nxt_chg_amt = eff_amt;
          end
        end
      end
      spca_pkg::ST_POS: begin
        nxt_step = pos_step;
        nxt_rem = rem_ff - pos_step;
        // Braking starts as soon as the remaining distance no longer
        // covers v^2/2a, which may be the very first position cycle
        if (need_dist <= kin) begin
          nxt_speed = (speed_ff > accel_ff) ? speed_ff - accel_ff : 32'h1;
        end else begin
          nxt_speed = ramp_up;
        end
        if (rem_ff == pos_step) begin
          nxt_state = spca_pkg::ST_IDLE;
          nxt_speed = 32'h0;
          nxt_done = 1'b1;
        end else if (stop_req) begin
          nxt_state = spca_pkg::ST_STOP;
        end
      end
      spca_pkg::ST_STOP: begin
        nxt_step = speed_ff;
        nxt_speed = (speed_ff > accel_ff) ? speed_ff - accel_ff : 32'h0;
        if (speed_ff == 32'h0) begin
          nxt_state = spca_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= spca_pkg::ST_IDLE;
      speed_ff <= 32'h0;
      rem_ff <= 32'h0;
      step_ff <= 32'h0;
      feed_ff <= 32'h0;
      chg_amt_ff <= 32'h0;
      dir_ff <= 1'b0;
      upd_ff <= 1'b0;
      stroke_ff <= 1'b0;
      mchg_ok_ff <= 1'b0;
      mchg_val_ff <= 32'h0;
      latch_ff <= 1'b0;
      lcnt_ff <= 32'h0;
      done_ff <= 1'b0;
      err_ff <= 16'h0;
      warn_ff <= 16'h0;
      spc_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      speed_ff <= nxt_speed;
      rem_ff <= nxt_rem;
      step_ff <= nxt_step;
      feed_ff <= nxt_feed;
      chg_amt_ff <= nxt_chg_amt;
      dir_ff <= nxt_dir;
      upd_ff <= nxt_upd;
      stroke_ff <= nxt_stroke;
      mchg_ok_ff <= nxt_mchg_ok;
      mchg_val_ff <= nxt_mchg_val;
      latch_ff <= nxt_latch;
      lcnt_ff <= nxt_lcnt;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
      warn_ff <= nxt_warn;
      spc_prev_ff <= nxt_spc_prev;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic chg_now;
  assign chg_now = (state_ff == spca_pkg::ST_SPEED) && spc_edge && en && !stop_req;

  AST_CHANGEOVER: assert property (chg_now && !stroke_ff |=> state_ff == spca_pkg::ST_POS)
    else $error("changeover did not enter position control");
  AST_NO_EN: assert property ((state_ff == spca_pkg::ST_SPEED) && !(spc_edge && en)
    |=> state_ff != spca_pkg::ST_POS)
    else $error("position control entered without enabled edge");
  AST_DIRECT_POS: assert property ((state_ff == spca_pkg::ST_IDLE) && start_req && en &&
    spc_in && pwdata[`SPCA_CTRL_ENABLE] && !pwdata[`SPCA_CTRL_CONTPATH] &&
    !pwdata[`SPCA_CTRL_INFINITE] && !pwdata[`SPCA_CTRL_PREVCONT]
    |=> state_ff == spca_pkg::ST_POS)
    else $error("start with enable and input did not skip speed section");
  AST_FEED_HOLD: assert property ((state_ff == spca_pkg::ST_SPEED) && !upd_ff
    |=> feed_ff == $past(feed_ff))
    else $error("feed value moved during speed section");
  AST_LATCH: assert property (chg_now ##1 (state_ff != spca_pkg::ST_IDLE || !start_req)
    |-> !latch_ff)
    else $error("latch flag set too early");
  AST_AMOUNT: assert property (chg_now && !stroke_ff |=> chg_amt_ff == $past(eff_amt) &&
    rem_ff == $past(eff_amt))
    else $error("monitor amount differs from effective amount");
  AST_MCHG_IGNORED: assert property (wr_en && at(paddr, `SPCA_OFS_MCHG) &&
    state_ff != spca_pkg::ST_SPEED |=> mchg_val_ff == $past(mchg_val_ff))
    else $error("amount change taken outside speed section");
  AST_CONTPATH: assert property ((state_ff == spca_pkg::ST_IDLE) && start_req &&
    pwdata[`SPCA_CTRL_CONTPATH] |=> state_ff == spca_pkg::ST_IDLE &&
    err_ff == `SPCA_ERR_CONTPATH)
    else $error("continuous path start not refused");
  AST_INFINITE: assert property ((state_ff == spca_pkg::ST_IDLE) && start_req &&
    !pwdata[`SPCA_CTRL_CONTPATH] && pwdata[`SPCA_CTRL_INFINITE]
    |=> state_ff == spca_pkg::ST_IDLE && err_ff == `SPCA_ERR_METHOD)
    else $error("infinite length start not refused");
  AST_WARN: assert property (chg_now && !stroke_ff && accel_busy
    |=> warn_ff == `SPCA_WARN_ACCEL)
    else $error("no warning for changeover during acceleration");

  COV_CHANGEOVER: cover property (chg_now ##1 state_ff == spca_pkg::ST_POS);
  COV_DONE: cover property ($rose(done_ff));
  COV_MCHG: cover property ((state_ff == spca_pkg::ST_SPEED) && wr_en &&
    at(paddr, `SPCA_OFS_MCHG));
  COV_LATCH: cover property ($rose(latch_ff));

endmodule
`default_nettype wire

// ===== tb/spca_servo_model.sv
// Servo drive stand-in: integrates the per-cycle step into a position.
// Assumes cmd_step and cmd_dir are registered outputs of the axis.
`timescale 1ns/1ps
`default_nettype none
module spca_servo_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Command from the axis
  input wire logic [31:0] cmd_step,
  input wire logic cmd_dir,
  // Integrated position
  output var logic signed [31:0] position
);
  logic signed [31:0] nxt_position;
  // ==========================================================
  // Integrator
  always_comb begin
    nxt_position = cmd_dir ? position - $signed(cmd_step) : position + $signed(cmd_step);
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      position <= 32'sh0;
    end else begin
      position <= nxt_position;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the speed/position changeover axis.
// Assumes zero-wait APB and a short latch delay parameter.
`timescale 1ns/1ps
`default_nettype none
`include "spca_regs.svh"
module tb_top;
  localparam int LC = 8;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, spc_in, cmd_dir, err_s;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cmd_step, rd, f0;
  logic signed [31:0] position, p0;
  int miscompares = 0;
  int check_count = 0;
  logic [31:0] bad_c [3] = '{32'h104, 32'h084, 32'h204};
  logic [31:0] bad_e [3] = '{32'h204, 32'h20C, 32'h204};
  spca_axis #(.LATCH_CYC(LC)) spca_axis_inst (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spc_in(spc_in), .cmd_step(cmd_step),
    .cmd_dir(cmd_dir));
  spca_servo_model spca_servo_model_inst (.clock(clock), .rst_n(rst_n),
    .cmd_step(cmd_step), .cmd_dir(cmd_dir), .position(position));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ==========================================================
  // Tasks
  task automatic end_of_test;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the whole request until pready is seen high at an edge, giving up after 20 more edges
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    if (n >= 20) miscompares++;
    rd = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `SPCA_OFS_STATUS, 32'h0);
      n++;
    end while (rd[2] !== 1'b0 && n < 300);
    if (n >= 300) miscompares++;
  endtask
  task automatic go(input logic [31:0] c, input logic [31:0] amt);
    apb(1'b0, `SPCA_OFS_FEED, 32'h0);
    f0 = rd;
    p0 = position;
    wr(`SPCA_OFS_MOVE, amt);
    wr(`SPCA_OFS_CTRL, c | 32'h1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, spc_in} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rst_n = 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(`SPCA_OFS_CTRL, 32'h0);
    rdc(`SPCA_OFS_ACCEL, `SPCA_RST_ACCEL);
    rdc(`SPCA_OFS_LIM_UP, `SPCA_RST_LIM_UP);
    rdc(`SPCA_OFS_LIM_LO, `SPCA_RST_LIM_LO);
    rdc(`SPCA_OFS_STATUS, 32'h0);
    rdc(`SPCA_OFS_ERROR, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err_s, 32'h1);
    chk(rd, 32'h0);
    wr(`SPCA_OFS_SPEED, 32'hA);
    wr(`SPCA_OFS_ACCEL, 32'h2);
    // Mode 0 forward, idle change request must not stick
    wr(`SPCA_OFS_MCHG, 32'h37);
    go(32'h04, 32'hC8);
    repeat (12) @(posedge clock);
    rdc(`SPCA_OFS_FEED, f0);
    apb(1'b0, `SPCA_OFS_STATUS, 32'h0);
    chk(rd[0], 32'h1);
    spc_in <= 1'b1;
    apb(1'b0, `SPCA_OFS_STATUS, 32'h0);
    chk(rd[1], 32'h0);
    repeat (6) @(posedge clock);
    apb(1'b0, `SPCA_OFS_STATUS, 32'h0);
    chk(rd[1], 32'h1);
    spc_in <= 1'b0;
    wr(`SPCA_OFS_MCHG, 32'h37);
    spc_in <= 1'b1;
    wait_idle();
    chk(rd[3:0], 32'hA);
    spc_in <= 1'b0;
    rdc(`SPCA_OFS_FEED, f0 + 32'hC8);
    rdc(`SPCA_OFS_CHGAMT, 32'hC8);
    chk(cmd_step, 32'h0);
    // Mode 1 reverse with a new amount
    go(32'h16, 32'hC8);
    repeat (12) @(posedge clock);
    wr(`SPCA_OFS_MCHG, 32'h78);
    apb(1'b0, `SPCA_OFS_FEED, 32'h0);
    chk(rd !== f0, 32'h1);
    chk(cmd_dir, 32'h1);
    spc_in <= 1'b1;
    wait_idle();
    spc_in <= 1'b0;
    rdc(`SPCA_OFS_FEED, f0 + (position - p0));
    rdc(`SPCA_OFS_CHGAMT, 32'h78);
    rdc(`SPCA_OFS_ERROR, 32'h0);
    // Mode 2 with an amount shorter than the braking distance
    go(32'h24, 32'hA);
    repeat (12) @(posedge clock);
    rdc(`SPCA_OFS_FEED, 32'h0);
    spc_in <= 1'b1;
    wait_idle();
    spc_in <= 1'b0;
    rdc(`SPCA_OFS_FEED, 32'hA);
    // Enable set after the input rose: stays in speed control
    go(32'h00, 32'hC8);
    repeat (12) @(posedge clock);
    spc_in <= 1'b1;
    repeat (2) @(posedge clock);
    wr(`SPCA_OFS_CTRL, 32'h04);
    repeat (10) @(posedge clock);
    apb(1'b0, `SPCA_OFS_STATUS, 32'h0);
    chk(rd[1:0], 32'h1);
    wr(`SPCA_OFS_CTRL, 32'h400);
    wait_idle();
    // Enable and input both on at start: position only
    go(32'h04, 32'h64);
    apb(1'b0, `SPCA_OFS_STATUS, 32'h0);
    chk(rd[0], 32'h0);
    wait_idle();
    spc_in <= 1'b0;
    rdc(`SPCA_OFS_FEED, f0 + 32'h64);
    rdc(`SPCA_OFS_CHGAMT, 32'h64);
    // Input during the ramp on purpose
    wr(`SPCA_OFS_ACCEL, 32'h1);
    wr(`SPCA_OFS_SPEED, 32'h28);
    go(32'h04, 32'h12C);
    spc_in <= 1'b1;
    wait_idle();
    spc_in <= 1'b0;
    rdc(`SPCA_OFS_ERROR, {`SPCA_WARN_ACCEL, 16'h0});
    wr(`SPCA_OFS_ERROR, 32'h0);
    wr(`SPCA_OFS_ACCEL, 32'h2);
    wr(`SPCA_OFS_SPEED, 32'hA);
    // Stroke limit: mode 1 mm, mode 1 degree, mode 0
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, `SPCA_OFS_FEED, 32'h0);
      wr(`SPCA_OFS_LIM_UP, rd + 32'h32);
      go(i == 2 ? 32'h04 : (i == 1 ? 32'h54 : 32'h14), 32'h64);
      repeat (20) @(posedge clock);
      spc_in <= 1'b1;
      wait_idle();
      spc_in <= 1'b0;
      rdc(`SPCA_OFS_ERROR, i == 0 ? {16'h0, `SPCA_ERR_STROKE_UP} : 32'h0);
      wr(`SPCA_OFS_ERROR, 32'h0);
    end
    wr(`SPCA_OFS_LIM_UP, `SPCA_RST_LIM_UP);
    // Refused or aborted entries
    for (int i = 0; i < 3; i++) begin
      go(bad_c[i], 32'h64);
      apb(1'b0, `SPCA_OFS_STATUS, 32'h0);
      if (i < 2) chk(rd[2], 32'h0);
      wait_idle();
      rdc(`SPCA_OFS_ERROR, bad_e[i]);
      wr(`SPCA_OFS_ERROR, 32'h0);
    end
    end_of_test();
  end
  // ==========================================================
  // Watchdog, well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
